// ---- rtl/disk_status_ctrl.sv ----
// Status and command-block control of a disk device, behind an AXI4-Lite slave.
// Assumes the drive engine shares core_clk and sends one-cycle event pulses.
// What this block does
// RULE1: Flags valid only while busy is clear
// RULE2: Host waits 400 ns before status read
// RULE3: Status and task file invalid in sleep
// RULE4: Status read clears pending interrupt
// RULE5: Command-block writes ignored while busy
// RULE6: Data request changes only while busy, except
// RULE7: Idle: only live flags may change
// RULE8: Busy within 400 ns of any reset
// RULE9: Busy within 400 ns of command accept
// RULE10: Busy set only at listed transfer points
// RULE11: Busy or data request until completion
// RULE12: Ready cleared at power on, set when able
// RULE13: Ready held in idle or standby modes
// RULE14: Ready changes once per status read
// RULE15: Not ready: reject all but two commands
// RULE16: Fault flag reports engine fault
// RULE17: Seek flag frozen after error until read
// RULE18: Data request when word transfer ready
// RULE19: Corrected flag never ends a transfer
// RULE20: Index flag passed through as given
// RULE21: Error context frozen until command or reset
// RULE22: Status byte bit layout fixed
// RULE23: Software reset bit holds device in reset
// RULE24: Interrupt driven only when enabled and selected
module disk_status_ctrl #(
  parameter int         ADDR_W    = 8,
  parameter logic       DEV_NUM   = 1'b0,
  parameter logic [7:0] DIAG_CODE = 8'h01, // Arbitrary, match the command set in use
  parameter logic [7:0] INIT_CODE = 8'h02  // Arbitrary, match the command set in use
) (
  input  wire logic              core_clk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output wire logic              awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output wire logic              wready,
  output wire logic [1:0]        bresp,
  output wire logic              bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output wire logic              arready,
  output wire logic [31:0]       rdata,
  output wire logic [1:0]        rresp,
  output wire logic              rvalid,
  input  wire logic              rready,
  output wire logic              cmd_start,
  output wire logic [7:0]        cmd_code,
  input  wire logic              eng_reset_done,
  input  wire logic              eng_data_ready,
  input  wire logic              eng_block_done,
  input  wire logic              eng_pio_in,
  input  wire logic              eng_last_block,
  input  wire logic              eng_cmd_done,
  input  wire logic              eng_err,
  input  wire logic [7:0]        eng_err_code,
  input  wire logic              eng_sleep,
  input  wire logic              eng_tf_we,
  input  wire logic [2:0]        eng_tf_idx,
  input  wire logic [7:0]        eng_tf_data,
  input  wire logic              eng_ready_all,
  input  wire logic              eng_pm_idle_stby,
  input  wire logic              eng_fault,
  input  wire logic              eng_seek_done,
  input  wire logic              eng_corr,
  input  wire logic              eng_index,
  output wire logic              intrq,
  output wire logic              intrq_oe
);
  localparam int BSY_LIM = disk_status_pkg::BSY_SET_CYC;

  if (ADDR_W < 8 || ADDR_W > 32) begin : g_chk
    $error("disk_status_ctrl: ADDR_W must be 8 to 32");
  end

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  function automatic logic tf_hit(input logic [ADDR_W-1:0] a);
    tf_hit = (a >= ADDR_W'(disk_status_pkg::OFS_TF_BASE)) && (a <= ADDR_W'(disk_status_pkg::OFS_TF_LAST))
             && (a[1:0] == 2'b00);
  endfunction

  function automatic logic [2:0] tf_idx(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - ADDR_W'(disk_status_pkg::OFS_TF_BASE);
    tf_idx = d[4:2];
  endfunction

  disk_status_pkg::dev_state_type state_reg, state_fsm, state_next;

  logic              aw_have_reg, w_have_reg, bvalid_reg;
  logic [ADDR_W-1:0] awaddr_reg, rofs_reg;
  logic [7:0]        wbyte_reg, error_reg, error_next, cmd_code_reg, rd_byte;
  logic              wlane_reg;
  logic [1:0]        bresp_reg, rresp_reg;
  logic              rd_busy_reg, rvalid_reg;
  logic [31:0]       rdata_reg;
  logic              err_reg, corr_reg, dsc_reg, dsc_frz_reg, df_reg, idx_reg;
  logic              drdy_reg, drdy_lock_reg, intr_reg, srst_reg, nien_reg;
  logic              devsel_reg, reject_reg, cmd_start_reg, cmd_open_reg;

  tf_bus_if tf ();

  tf_regfile #(.WORDS(disk_status_pkg::TF_WORDS)) u_tf (
    .core_clk (core_clk),
    .resetn   (resetn),
    .bus      (tf.mem)
  );

  // Write channel: address and data are parked until both have arrived
  assign awready = !aw_have_reg && !bvalid_reg;
  assign wready  = !w_have_reg && !bvalid_reg;
  wire aw_take   = awvalid && awready;
  wire w_take    = wvalid && wready;
  wire wr_do     = aw_have_reg && w_have_reg;
  wire wr_lane   = wr_do && wlane_reg;
  wire wr_cmd    = wr_lane && hit(awaddr_reg, disk_status_pkg::OFS_CMD);
  wire wr_ctl    = wr_lane && hit(awaddr_reg, disk_status_pkg::OFS_DEVCTL);
  wire wr_tf     = wr_lane && tf_hit(awaddr_reg);
  wire wr_map    = hit(awaddr_reg, disk_status_pkg::OFS_CMD) || hit(awaddr_reg, disk_status_pkg::OFS_DEVCTL)
                   || tf_hit(awaddr_reg);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
    end else begin
      aw_have_reg <= aw_take || (aw_have_reg && !wr_do);
      w_have_reg  <= w_take || (w_have_reg && !wr_do);
      if (aw_take) awaddr_reg <= awaddr;
      if (w_take) wbyte_reg <= wdata[7:0];
      if (w_take) wlane_reg <= wstrb[0];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= disk_status_pkg::RESP_OKAY;
    end else begin
      bvalid_reg <= wr_do || (bvalid_reg && !bready);
      if (wr_do) bresp_reg <= wr_map ? disk_status_pkg::RESP_OKAY : disk_status_pkg::RESP_SLVERR;
    end
  end

  assign bvalid = bvalid_reg;
  assign bresp  = bresp_reg;

  // Device status decode
  wire bsy     = (state_reg == disk_status_pkg::st_reset) || (state_reg == disk_status_pkg::st_cmd);
  wire drq     = (state_reg == disk_status_pkg::st_drq); // RULE18
  wire asleep  = (state_reg == disk_status_pkg::st_sleep);
  wire accept  = wr_cmd && (state_reg == disk_status_pkg::st_idle); // RULE5
  wire cmd_ok  = drdy_reg || (wbyte_reg == DIAG_CODE) || (wbyte_reg == INIT_CODE); // RULE15
  wire srst_set = wr_ctl && wbyte_reg[disk_status_pkg::SRST_BIT];
  wire in_cmd  = (state_reg == disk_status_pkg::st_cmd);
  wire pio_last = drq && eng_block_done && eng_pio_in && eng_last_block;
  wire cmd_fin = in_cmd && (reject_reg || (!eng_data_ready && eng_cmd_done));
  wire err_set = cmd_fin && (reject_reg || eng_err);
  wire ar_take = arvalid && arready;
  wire stat_rd = ar_take && hit(araddr, disk_status_pkg::OFS_STATUS);
  wire intr_set = cmd_fin || (in_cmd && eng_data_ready);
  wire drdy_tgt = eng_ready_all || eng_pm_idle_stby; // RULE12 RULE13
  wire drdy_chg = (drdy_tgt != drdy_reg) && !drdy_lock_reg; // RULE14

  always_comb begin
    state_fsm = state_reg;
    unique case (state_reg)
      disk_status_pkg::st_reset: if (eng_reset_done) state_fsm = disk_status_pkg::st_idle; // RULE8
      disk_status_pkg::st_idle:  if (accept) state_fsm = disk_status_pkg::st_cmd; // RULE9 RULE11
      disk_status_pkg::st_cmd: begin
        // Busy stays up through DMA until the engine finishes
        if (reject_reg) state_fsm = disk_status_pkg::st_idle;
        else if (eng_data_ready) state_fsm = disk_status_pkg::st_drq; // RULE6 RULE11
        else if (eng_cmd_done && eng_sleep) state_fsm = disk_status_pkg::st_sleep;
        else if (eng_cmd_done) state_fsm = disk_status_pkg::st_idle;
      end
      disk_status_pkg::st_drq: begin
        if (pio_last) state_fsm = disk_status_pkg::st_idle; // RULE6
        else if (eng_block_done) state_fsm = disk_status_pkg::st_cmd; // RULE10
      end
      disk_status_pkg::st_sleep: state_fsm = disk_status_pkg::st_sleep; // RULE3
      default: state_fsm = disk_status_pkg::st_reset;
    endcase
  end

  // Software reset overrides everything, sleep included
  assign state_next = (srst_set || srst_reg) ? disk_status_pkg::st_reset : state_fsm; // RULE8 RULE23
  wire going_reset  = (state_next == disk_status_pkg::st_reset);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) state_reg <= disk_status_pkg::st_reset; // RULE8
    else state_reg <= state_next;
  end

  // Device control is outside the command block, so busy does not block it
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      srst_reg <= 1'b0;
      nien_reg <= 1'b0;
    end else if (wr_ctl) begin
      srst_reg <= wbyte_reg[disk_status_pkg::SRST_BIT]; // RULE23
      nien_reg <= wbyte_reg[disk_status_pkg::NIEN_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      reject_reg    <= 1'b0;
      cmd_start_reg <= 1'b0;
      cmd_code_reg  <= 8'h00;
      cmd_open_reg  <= 1'b0;
    end else begin
      reject_reg    <= accept && !cmd_ok; // RULE15
      cmd_start_reg <= accept && cmd_ok;
      if (accept) cmd_code_reg <= wbyte_reg;
      cmd_open_reg  <= !going_reset && (accept || (cmd_open_reg && !cmd_fin && !pio_last));
    end
  end

  assign error_next = reject_reg ? (8'h01 << disk_status_pkg::ABRT_BIT) : eng_err_code;

  // Error context changes only on a new command, a completion or a reset
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      err_reg   <= 1'b0;
      error_reg <= disk_status_pkg::ERR_RESET_VAL;
    end else if (going_reset || accept) begin
      err_reg   <= 1'b0; // RULE21
      error_reg <= disk_status_pkg::ERR_RESET_VAL;
    end else if (err_set) begin
      err_reg   <= 1'b1; // RULE15
      error_reg <= error_next;
    end
  end

  // Live flags: these, and ready, may move while busy is clear
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      df_reg      <= 1'b0;
      idx_reg     <= 1'b0;
      corr_reg    <= 1'b0;
      dsc_reg     <= 1'b0;
      dsc_frz_reg <= 1'b0;
    end else begin
      df_reg      <= eng_fault; // RULE16 RULE7
      idx_reg     <= eng_index; // RULE20
      corr_reg    <= eng_corr || (corr_reg && !accept); // RULE19
      dsc_frz_reg <= err_set || (dsc_frz_reg && !stat_rd); // RULE17
      if (!dsc_frz_reg || stat_rd) dsc_reg <= eng_seek_done;
    end
  end

  // The lock may delay a ready change until software looks; a missed poll costs latency only
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      drdy_reg      <= 1'b0; // RULE12
      drdy_lock_reg <= 1'b0;
      intr_reg      <= 1'b0;
    end else begin
      if (drdy_chg) drdy_reg <= drdy_tgt;
      drdy_lock_reg <= drdy_chg || (drdy_lock_reg && !stat_rd); // RULE14
      intr_reg      <= !going_reset && (intr_set || (intr_reg && !stat_rd)); // RULE4
    end
  end

  // Task file: host writes while idle with the error flag clear, engine writes while busy
  wire host_tf_we = wr_tf && !bsy && !asleep && !drq && !err_reg; // RULE5 RULE7 RULE21
  wire eng_tf_ok  = eng_tf_we && bsy; // RULE7
  assign tf.we    = host_tf_we || eng_tf_ok;
  assign tf.waddr = host_tf_we ? tf_idx(awaddr_reg) : eng_tf_idx;
  assign tf.wdata = host_tf_we ? wbyte_reg : eng_tf_data;
  assign tf.raddr = tf_idx(araddr);

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) devsel_reg <= 1'b0;
    else if (tf.we && tf.waddr == disk_status_pkg::TF_DEVHD) devsel_reg <= tf.wdata[disk_status_pkg::DEV_BIT];
  end

  assign intrq    = intr_reg;
  assign intrq_oe = !nien_reg && (devsel_reg == DEV_NUM); // RULE24

  // Status byte; the other flags mean nothing while busy is set
  logic [7:0] status_byte;
  always_comb begin
    status_byte = 8'h00;
    status_byte[disk_status_pkg::BSY_BIT]  = bsy; // RULE22 RULE1
    status_byte[disk_status_pkg::DRDY_BIT] = drdy_reg;
    status_byte[disk_status_pkg::DF_BIT]   = df_reg;
    status_byte[disk_status_pkg::DSC_BIT]  = dsc_reg;
    status_byte[disk_status_pkg::DRQ_BIT]  = drq;
    status_byte[disk_status_pkg::CORR_BIT] = corr_reg;
    status_byte[disk_status_pkg::IDX_BIT]  = idx_reg;
    status_byte[disk_status_pkg::ERR_BIT]  = err_reg;
  end

  // Read channel: one cycle for the store lookup, then the registered answer
  assign arready = !rd_busy_reg && !rvalid_reg;
  wire r_stat = hit(rofs_reg, disk_status_pkg::OFS_STATUS) || hit(rofs_reg, disk_status_pkg::OFS_ALTSTAT);
  wire r_err  = hit(rofs_reg, disk_status_pkg::OFS_ERROR);
  wire r_ctl  = hit(rofs_reg, disk_status_pkg::OFS_DEVCTL);
  wire r_tf   = tf_hit(rofs_reg);
  wire r_map  = r_stat || r_err || r_ctl || r_tf;
  wire [7:0] ctl_byte = {5'b00000, srst_reg, nien_reg, 1'b0};
  assign rd_byte = asleep ? 8'h00 : // RULE3
                   r_stat ? status_byte :
                   r_err  ? error_reg :
                   r_ctl  ? ctl_byte :
                   r_tf   ? tf.rdata : 8'h00;

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rd_busy_reg <= 1'b0;
      rofs_reg    <= '0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= disk_status_pkg::RESP_OKAY;
    end else begin
      rd_busy_reg <= ar_take;
      if (ar_take) rofs_reg <= araddr;
      rvalid_reg  <= rd_busy_reg || (rvalid_reg && !rready);
      if (rd_busy_reg) rdata_reg <= {24'h000000, rd_byte};
      if (rd_busy_reg) rresp_reg <= r_map ? disk_status_pkg::RESP_OKAY : disk_status_pkg::RESP_SLVERR;
    end
  end

  assign rvalid    = rvalid_reg;
  assign rdata     = rdata_reg;
  assign rresp     = rresp_reg;
  assign cmd_start = cmd_start_reg;
  assign cmd_code  = cmd_code_reg;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  srst_busy_a: assert property (srst_set |-> ##[1:BSY_LIM] (bsy && !drq)) // RULE8
    else $error("busy not raised after software reset");
  accept_busy_a: assert property (accept |=> bsy && !drq) // RULE9
    else $error("busy not raised after command accept");
  open_cover_a: assert property (cmd_open_reg |-> (bsy || drq)) // RULE11
    else $error("command open with neither busy nor data request");
  drq_change_a: assert property ($changed(drq) |-> $past(bsy) || ($fell(drq) && $past(pio_last))) // RULE6
    else $error("data request moved while not busy");
  busy_write_a: assert property ((wr_tf && bsy && tf_idx(awaddr_reg) == disk_status_pkg::TF_DEVHD) // RULE5
                                 |=> devsel_reg == $past(devsel_reg))
    else $error("command block written while busy");
  err_hold_a: assert property ((err_reg && !accept && !going_reset) |=> err_reg && $stable(error_reg)) // RULE21
    else $error("error context changed while frozen");
  drdy_lock_a: assert property ((drdy_lock_reg && !stat_rd) |=> $stable(drdy_reg)) // RULE14
    else $error("ready changed twice without status read");
  intr_clear_a: assert property ((stat_rd && !intr_set) |=> !intr_reg) // RULE4
    else $error("status read left interrupt pending");
  reject_abort_a: assert property ((accept && !cmd_ok && !srst_reg) |=> bsy ##1 // RULE15
                                   (!bsy && err_reg && error_reg[disk_status_pkg::ABRT_BIT]))
    else $error("disallowed command not aborted");
  dsc_frozen_a: assert property ((dsc_frz_reg && !stat_rd) |=> $stable(dsc_reg)) // RULE17
    else $error("seek flag moved while frozen");
  intr_gate_a: assert property ((wr_ctl && wbyte_reg[disk_status_pkg::NIEN_BIT]) |=> !intrq_oe[*2]) // RULE24
    else $error("interrupt driven while disabled");

  accept_c: cover property (accept ##1 bsy ##[1:30] drq);
  pio_end_c: cover property (pio_last ##1 (!bsy && !drq));
  reject_c: cover property (accept && !cmd_ok);
  stat_clr_c: cover property (intr_reg && stat_rd);
endmodule

// ---- shared/disk_status_pkg.sv ----
// Constants shared by the status controller and its task-file store.
// Assumes a 200 MHz core clock and a byte-wide command block.
package disk_status_pkg;
  localparam int CLK_PERIOD_NS = 5;
  localparam int BSY_SET_NS    = 400;
  localparam int BSY_SET_CYC   = BSY_SET_NS / CLK_PERIOD_NS;

  localparam logic [7:0] OFS_STATUS  = 8'h00;
  localparam logic [7:0] OFS_ALTSTAT = 8'h04;
  localparam logic [7:0] OFS_CMD     = 8'h08;
  localparam logic [7:0] OFS_DEVCTL  = 8'h0c;
  localparam logic [7:0] OFS_ERROR   = 8'h10;
  localparam logic [7:0] OFS_TF_BASE = 8'h14;
  localparam logic [7:0] OFS_TF_LAST = 8'h28;

  localparam int BSY_BIT  = 7;
  localparam int DRDY_BIT = 6;
  localparam int DF_BIT   = 5;
  localparam int DSC_BIT  = 4;
  localparam int DRQ_BIT  = 3;
  localparam int CORR_BIT = 2;
  localparam int IDX_BIT  = 1;
  localparam int ERR_BIT  = 0;
  localparam int SRST_BIT = 2;
  localparam int NIEN_BIT = 1;
  localparam int DEV_BIT  = 4;
  localparam int ABRT_BIT = 3;

  localparam logic [2:0] TF_FEAT  = 3'h0;
  localparam logic [2:0] TF_SCNT  = 3'h1;
  localparam logic [2:0] TF_SNUM  = 3'h2;
  localparam logic [2:0] TF_CYLL  = 3'h3;
  localparam logic [2:0] TF_CYLH  = 3'h4;
  localparam logic [2:0] TF_DEVHD = 3'h5;
  localparam int         TF_WORDS = 6;

  localparam logic [7:0] TF_RESET_VAL = 8'h00;
  localparam logic [7:0] ERR_RESET_VAL = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [2:0] {
    st_reset = 3'b000,
    st_idle  = 3'b001,
    st_cmd   = 3'b011,
    st_drq   = 3'b010,
    st_sleep = 3'b110
  } dev_state_type;
endpackage

// ---- shared/tf_bus_if.sv ----
// Port between the status controller and the task-file store.
// Assumes one writer per cycle and a read answer one clock later.
interface tf_bus_if;
  logic       we;
  logic [2:0] waddr;
  logic [7:0] wdata;
  logic [2:0] raddr;
  logic [7:0] rdata;
  modport ctrl (output we, output waddr, output wdata, output raddr, input rdata);
  modport mem  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// ---- rtl/tf_regfile.sv ----
// Task-file byte store: sector count, address and device/head bytes.
// Assumes the controller never writes while it is reading the same cycle's data.
module tf_regfile #(
  parameter int WORDS = disk_status_pkg::TF_WORDS
) (
  input wire logic core_clk,
  input wire logic resetn,
  tf_bus_if.mem    bus
);
  logic [7:0] mem_reg [WORDS];
  logic [7:0] rdata_reg;

  if (WORDS < 1 || WORDS > 8) begin : g_chk
    $error("tf_regfile: WORDS must be 1 to 8");
  end

  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < WORDS; i++) begin
        mem_reg[i] <= disk_status_pkg::TF_RESET_VAL;
      end
    end else if (bus.we && int'(bus.waddr) < WORDS) begin
      mem_reg[bus.waddr] <= bus.wdata;
    end
  end

  // Out-of-range index reads zero rather than an undefined word
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_reg <= disk_status_pkg::TF_RESET_VAL;
    end else begin
      rdata_reg <= (int'(bus.raddr) < WORDS) ? mem_reg[bus.raddr] : 8'h00;
    end
  end

  assign bus.rdata = rdata_reg;
endmodule

// ---- test/disk_engine_model.sv ----
// Drive engine stand-in: answers each accepted command with one PIO data-in block.
// Assumes the controller pulses cmd_start for one core_clk cycle.
module disk_engine_model (
  input  wire logic       core_clk,
  input  wire logic       cmd_start,
  output logic            eng_data_ready,
  output logic            eng_block_done,
  output logic            eng_tf_we,
  output logic [2:0]      eng_tf_idx,
  output logic [7:0]      eng_tf_data,
  output logic            eng_pio_in,
  output logic            eng_last_block,
  output logic            eng_cmd_done,
  output logic            eng_err,
  output logic [7:0]      eng_err_code,
  output logic            eng_sleep
);
  timeunit 1ns;
  timeprecision 1ps;
  // Single last-block read only; error and sleep endings are not exercised here
  assign eng_tf_idx = disk_status_pkg::TF_CYLL;
  assign eng_tf_data = 8'h5a;
  assign eng_pio_in = 1'b1;
  assign eng_last_block = 1'b1;
  assign eng_cmd_done = 1'b0;
  assign eng_err = 1'b0;
  assign eng_err_code = 8'h00;
  assign eng_sleep = 1'b0;
  initial begin
    eng_data_ready = 1'b0;
    eng_block_done = 1'b0;
    eng_tf_we = 1'b0;
  end
  // Slow answer on purpose, so the bench can look at busy in between
  always begin
    @(negedge core_clk);
    if (cmd_start === 1'b1) begin
      repeat (20) @(posedge core_clk);
      eng_data_ready <= 1'b1;
      eng_tf_we <= 1'b1;
      @(posedge core_clk);
      eng_data_ready <= 1'b0;
      eng_tf_we <= 1'b0;
      repeat (30) @(posedge core_clk);
      eng_block_done <= 1'b1;
      @(posedge core_clk);
      eng_block_done <= 1'b0;
    end
  end
endmodule

// ---- test/disk_device_status_logic_bench.sv ----
// Self-checking bench for the disk status controller over AXI4-Lite.
// Assumes the engine model answers commands; the bench plays the host.
module disk_device_status_logic_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] CYLL_ADR = 8'h20;
  logic        core_clk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, cmd_start, intrq, intrq_oe;
  logic        eng_reset_done, eng_data_ready, eng_block_done, eng_pio_in, eng_last_block;
  logic        eng_cmd_done, eng_err, eng_sleep, eng_tf_we, eng_ready_all, eng_fault;
  logic        eng_seek_done, eng_corr, eng_index;
  logic [7:0]  awaddr, araddr, cmd_code, eng_err_code, eng_tf_data;
  logic [2:0]  eng_tf_idx;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rsp;
  logic [31:0] wdata, rdata, rd;
  int          error_cnt, total_checks, cycles;
  logic        eng_pm_idle_stby = 1'b0;

  disk_status_ctrl i_disk_status_ctrl (.core_clk, .resetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .cmd_start, .cmd_code, .eng_reset_done, .eng_data_ready, .eng_block_done, .eng_pio_in,
    .eng_last_block, .eng_cmd_done, .eng_err, .eng_err_code, .eng_sleep, .eng_tf_we, .eng_tf_idx,
    .eng_tf_data, .eng_ready_all, .eng_pm_idle_stby, .eng_fault, .eng_seek_done, .eng_corr, .eng_index,
    .intrq, .intrq_oe);
  disk_engine_model i_disk_engine_model (.core_clk, .cmd_start, .eng_data_ready, .eng_block_done,
    .eng_tf_we, .eng_tf_idx, .eng_tf_data, .eng_pio_in, .eng_last_block, .eng_cmd_done, .eng_err,
    .eng_err_code, .eng_sleep);

  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  // Ceiling well above the few hundred cycles the scenarios need
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      close_out;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic close_out;
    if (error_cnt == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // Ready is a level of registers, so it is looked at on the falling edge before the take
  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge core_clk);
    awaddr <= a;
    wdata <= {24'h0, d};
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(negedge core_clk);
      aw_ok = aw_ok | awready;
      w_ok = w_ok | wready;
      @(posedge core_clk);
      if (aw_ok) awvalid <= 1'b0;
      if (w_ok) wvalid <= 1'b0;
    end
    do @(negedge core_clk); while (bvalid !== 1'b1);
    chk(32'(bresp), 32'(er));
    @(posedge core_clk);
    bready <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a);
    @(posedge core_clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge core_clk); while (arready !== 1'b1);
    @(posedge core_clk);
    arvalid <= 1'b0;
    do @(negedge core_clk); while (rvalid !== 1'b1);
    rd = rdata;
    rsp = rresp;
    @(posedge core_clk);
    rready <= 1'b0;
  endtask
  task automatic reset_finish;
    @(posedge core_clk);
    eng_reset_done <= 1'b1;
    @(posedge core_clk);
    eng_reset_done <= 1'b0;
  endtask

  task automatic t_reset;
    rd_reg(disk_status_pkg::OFS_STATUS);
    chk(rd, 32'h80);
    chk(32'(intrq_oe), 32'h1);
    reset_finish;
    rd_reg(disk_status_pkg::OFS_STATUS);
    chk(rd, 32'h00);
  endtask
  task automatic t_reject;
    wr(disk_status_pkg::OFS_CMD, 8'h20, disk_status_pkg::RESP_OKAY);
    cyc(4);
    rd_reg(disk_status_pkg::OFS_ERROR);
    chk(rd, 32'h1 << disk_status_pkg::ABRT_BIT);
    chk(32'(intrq), 32'h1);
    rd_reg(disk_status_pkg::OFS_STATUS);
    chk(rd, 32'h01);
    chk(32'(intrq), 32'h0);
    wr(CYLL_ADR, 8'h33, disk_status_pkg::RESP_OKAY);
    rd_reg(CYLL_ADR);
    chk(rd, 32'h00);
  endtask
  // Ready rises then its source falls before any status read: the first value must hold
  task automatic t_ready;
    eng_ready_all <= 1'b1;
    cyc(3);
    eng_ready_all <= 1'b0;
    cyc(3);
    rd_reg(disk_status_pkg::OFS_STATUS);
    chk(rd, 32'h41);
    eng_pm_idle_stby <= 1'b1;
    rd_reg(disk_status_pkg::OFS_STATUS);
    chk(rd, 32'h01);
    cyc(3);
    rd_reg(disk_status_pkg::OFS_STATUS);
    chk(rd, 32'h41);
  endtask
  task automatic t_command;
    wr(disk_status_pkg::OFS_CMD, 8'h30, disk_status_pkg::RESP_OKAY);
    chk(32'(cmd_code), 32'h30);
    rd_reg(disk_status_pkg::OFS_ALTSTAT);
    chk(32'(rd[7]), 32'h1);
    wr(disk_status_pkg::OFS_TF_LAST, 8'h77, disk_status_pkg::RESP_OKAY);
    cyc(25);
    rd_reg(disk_status_pkg::OFS_ALTSTAT);
    chk(rd, 32'h48);
    chk(32'(intrq), 32'h1);
    // Wait well past 400 ns after the last block, so busy can be trusted
    cyc(100);
    rd_reg(disk_status_pkg::OFS_ALTSTAT);
    chk(rd, 32'h40);
    rd_reg(CYLL_ADR);
    chk(rd, 32'h5a);
    rd_reg(disk_status_pkg::OFS_TF_LAST);
    chk(rd, 32'h00);
  endtask
  task automatic t_live;
    eng_fault <= 1'b1;
    eng_seek_done <= 1'b1;
    eng_index <= 1'b1;
    eng_corr <= 1'b1;
    cyc(1);
    eng_corr <= 1'b0;
    cyc(3);
    rd_reg(disk_status_pkg::OFS_STATUS);
    chk(rd, 32'h76);
    chk(32'(intrq), 32'h0);
  endtask
  task automatic t_srst;
    wr(disk_status_pkg::OFS_DEVCTL, 8'h06, disk_status_pkg::RESP_OKAY);
    rd_reg(disk_status_pkg::OFS_ALTSTAT);
    chk(32'(rd[7]), 32'h1);
    chk(32'(intrq_oe), 32'h0);
    wr(disk_status_pkg::OFS_DEVCTL, 8'h00, disk_status_pkg::RESP_OKAY);
    reset_finish;
    rd_reg(disk_status_pkg::OFS_ALTSTAT);
    chk(32'(rd[7]), 32'h0);
    chk(32'(intrq_oe), 32'h1);
  endtask
  task automatic t_bus;
    rd_reg(8'h40);
    chk(32'(rsp), 32'(disk_status_pkg::RESP_SLVERR));
    chk(rd, 32'h0);
    wr(disk_status_pkg::OFS_STATUS, 8'hff, disk_status_pkg::RESP_SLVERR);
  endtask

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, eng_reset_done} = '0;
    {eng_ready_all, eng_fault, eng_seek_done, eng_corr, eng_index} = '0;
    awaddr = '0;
    araddr = '0;
    wdata = '0;
    wstrb = '0;
    resetn = 1'b0;
    repeat (20) @(posedge core_clk);
    resetn <= 1'b1;
    t_reset;
    t_reject;
    t_ready;
    t_command;
    t_live;
    t_srst;
    t_bus;
    close_out;
  end
endmodule
